// >>> vectored_priority_interrupt_ctrl_bench.sv
// Self-checking bench for the vectored interrupt controller
module vectored_priority_interrupt_ctrl_bench
  import vic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] lvl = 32'h0;
  logic [31:0] src;
  logic [31:0] rdata;
  logic [31:0] got;
  logic [31:0] w;
  logic nrq;
  logic frq;
  logic evirq;
  wire logic [2:0] lines = {evirq, frq, nrq};
  int n_fail = 0;
  int samples_checked = 0;
  int n;
  int tsrc [2] = '{7, 28};
  logic [31:0] rst_a [10] = '{VIC_ADDR_SMR_BASE, 32'hfffff07c, VIC_ADDR_SVR_BASE, 32'hfffff0fc,
    VIC_ADDR_IVR, VIC_ADDR_FVR, VIC_ADDR_ISR, VIC_ADDR_IMR, VIC_ADDR_CISR, VIC_ADDR_SPU};
  vic_src_model u_src (.clk_i(clk), .lvl_i(lvl), .src_o(src));
  vic_top dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s),
    .RDATA_O(rdata), .SRC_I(src), .NORMAL_REQUEST_N_O(nrq), .FAST_REQUEST_N_O(frq), .EVENT_IRQ_O(evirq));
  always #10 clk = ~clk;
  // ****
  // Access and check tasks
  // ****
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rdv(input logic [31:0] a);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    got = rdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rdv(a);
    chk(got, e);
  endtask
  task automatic src_set(input int k, input logic v);
    @(posedge clk);
    lvl[k] <= v;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wt(input int b, input logic v);
    for (int i = 0; i < 40 && lines[b] !== v; i++) @(posedge clk) #1;
    chk(32'(lines[b]), 32'(v));
    if (lines[b] !== v) final_report();
  endtask
  function automatic logic [31:0] smr(input int k);
    return VIC_ADDR_SMR_BASE + 32'(4 * k);
  endfunction
  // Pending after low, high, low phases of the line
  function automatic logic pexp(input bit ext, input int t, input int s);
    if (s == 0) return ext && t == 0;
    if (s == 1) return !ext || t >= 2;
    return t % 2 == 1 || (ext && t == 0);
  endfunction
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rst_a[i]) rd(rst_a[i], 32'h0);
    for (int k = 0; k < 32; k++) wr(VIC_ADDR_SVR_BASE + 32'(4 * k), 32'h1000 + 32'(k));
    rd(32'hfffff0fc, 32'h101f);
    wr(VIC_ADDR_SPU, 32'hdead0000);
    wr(VIC_ADDR_EVT_CLR, 32'h7);
    wr(VIC_ADDR_EVT_EN, 32'h1);
    foreach (tsrc[j]) for (int t = 0; t < 4; t++) begin
      n = tsrc[j];
      w = 32'h7 | 32'(t) << 5;
      wr(smr(n), w);
      rd(smr(n), n == 28 ? w : w & 32'hffffffbf);
      wr(VIC_ADDR_ICCR, 32'h1 << n);
      for (int s = 0; s < 3; s++) begin
        src_set(n, s == 1);
        idle(8);
        rdv(VIC_ADDR_IPR);
        chk(32'(got[n]), 32'(pexp(n == 28, t, s)));
      end
    end
    chk(32'(evirq), 32'h0);
    wr(smr(3), 32'h2);
    wr(smr(4), 32'h5);
    wr(smr(5), 32'h5);
    wr(VIC_ADDR_IECR, 32'h38);
    rd(VIC_ADDR_IMR, 32'h38);
    src_set(3, 1'b1);
    wt(0, 1'b0);
    rd(VIC_ADDR_IVR, 32'h1003);
    chk(32'(nrq), 32'h1);
    src_set(4, 1'b1);
    src_set(5, 1'b1);
    wt(0, 1'b0);
    rd(VIC_ADDR_IVR, 32'h1004);
    rd(VIC_ADDR_ISR, 32'h4);
    rd(VIC_ADDR_IVR, 32'hdead0000);
    wt(2, 1'b1);
    rd(VIC_ADDR_EVT_STAT, 32'h1);
    wr(VIC_ADDR_EVT_CLR, 32'h1);
    wt(2, 1'b0);
    src_set(4, 1'b0);
    idle(8);
    wr(VIC_ADDR_EOICR, 32'h0);
    wt(0, 1'b0);
    rd(VIC_ADDR_IVR, 32'h1005);
    src_set(5, 1'b0);
    idle(8);
    wr(VIC_ADDR_EOICR, 32'h0);
    idle(8);
    chk(32'(nrq), 32'h1);
    rd(VIC_ADDR_ISR, 32'h3);
    src_set(3, 1'b0);
    idle(8);
    wr(VIC_ADDR_EOICR, 32'h0);
    rd(VIC_ADDR_ISR, 32'h0);
    wr(smr(6), 32'h21);
    wr(VIC_ADDR_ISCR, 32'h40);
    rdv(VIC_ADDR_IPR);
    chk(32'(got[6]), 32'h1);
    wr(VIC_ADDR_ICCR, 32'h40);
    rdv(VIC_ADDR_IPR);
    chk(32'(got[6]), 32'h0);
    wr(VIC_ADDR_ISCR, 32'h40);
    wr(VIC_ADDR_IECR, 32'h40);
    wt(0, 1'b0);
    rd(VIC_ADDR_IVR, 32'h1006);
    rdv(VIC_ADDR_IPR);
    chk(32'(got[6]), 32'h0);
    wr(VIC_ADDR_EOICR, 32'h0);
    wr(smr(0), 32'h47);
    wr(VIC_ADDR_EVT_EN, 32'h0);
    wr(VIC_ADDR_IECR, 32'h9);
    src_set(0, 1'b1);
    wt(1, 1'b0);
    idle(3);
    chk(32'(nrq), 32'h1);
    rd(VIC_ADDR_CISR, 32'h1);
    rd(VIC_ADDR_FVR, 32'h1000);
    src_set(3, 1'b1);
    wt(0, 1'b0);
    rd(VIC_ADDR_IVR, 32'h1003);
    src_set(0, 1'b0);
    src_set(3, 1'b0);
    wt(1, 1'b1);
    rd(VIC_ADDR_FVR, 32'hdead0000);
    idle(2);
    chk(32'(evirq), 32'h0);
    rd(VIC_ADDR_EVT_STAT, 32'h2);
    wr(VIC_ADDR_EOICR, 32'h0);
    wr(VIC_ADDR_IDCR, 32'h7f);
    rd(VIC_ADDR_IMR, 32'h0);
    wr(VIC_ADDR_EOICR, 32'h0);
    rd(VIC_ADDR_EVT_STAT, 32'h6);
    for (int a = 'h118; a < 'h134; a += 4) rd(32'hfffff000 + 32'(a), 32'h0);
    rd(32'hfffff200, 32'h0);
    final_report();
  end
endmodule

// >>> vic_chk.sv
// Port-level assertions for the interrupt controller
module vic_chk
  import vic_pkg::*;
#(
  parameter logic [VIC_NSRC-1:0] EXT_SRC = VIC_EXT_SRC_DEFAULT
) (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic [31:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic NORMAL_REQUEST_N_O,
  input wire logic FAST_REQUEST_N_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Decode and shadows
  // ****
  logic [31:0] spu_r;
  logic [31:0] vec0_r;
  wire logic rd_ivr = RD_I && ADDR_I == VIC_ADDR_IVR;
  wire logic rd_fvr = RD_I && ADDR_I == VIC_ADDR_FVR;
  wire logic rd_cmd = RD_I && ADDR_I >= 32'hfffff118 && ADDR_I <= VIC_ADDR_EOICR;
  wire logic rd_int = RD_I && ADDR_I[31:7] == VIC_ADDR_SMR_BASE[31:7] && !EXT_SRC[ADDR_I[6:2]];
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      spu_r <= 32'h0;
      vec0_r <= 32'h0;
    end else if (WR_I && ADDR_I == VIC_ADDR_SPU) begin
      spu_r <= WDATA_I;
    end else if (WR_I && ADDR_I == VIC_ADDR_SVR_BASE) begin
      vec0_r <= WDATA_I;
    end
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  read_idle_a: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data not zero");
  ivr_drop_a: assert property (rd_ivr && !NORMAL_REQUEST_N_O |=> NORMAL_REQUEST_N_O)
    else $error("normal request kept after vector read");
  ivr_spur_a: assert property (rd_ivr && NORMAL_REQUEST_N_O |=> RDATA_O == spu_r)
    else $error("idle normal vector not spurious");
  fvr_spur_a: assert property (rd_fvr && FAST_REQUEST_N_O |=> RDATA_O == spu_r)
    else $error("idle fast vector not spurious");
  fast_vec_a: assert property (rd_fvr && !FAST_REQUEST_N_O |=> RDATA_O == vec0_r)
    else $error("fast vector not source 0 vector");
  int_type_a: assert property (rd_int |=> RDATA_O[31:6] == 26'h0)
    else $error("internal mode upper bits set");
  cmd_read_a: assert property (rd_cmd |=> RDATA_O == 32'h0)
    else $error("command register read not zero");
  line_stat_a: assert property (RD_I && ADDR_I == VIC_ADDR_CISR |=>
    RDATA_O == {30'h0, !$past(NORMAL_REQUEST_N_O), !$past(FAST_REQUEST_N_O)})
    else $error("core line status differs from lines");
endmodule

bind vic_top vic_chk #(.EXT_SRC(EXT_SRC)) u_vic_chk (.CLK_SYS_I, .RSTN_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
  .RDATA_O, .NORMAL_REQUEST_N_O, .FAST_REQUEST_N_O);

// >>> vic_pkg.sv
// Package of constants and types for the vectored interrupt controller
package vic_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned VIC_NSRC = 32;
  localparam int unsigned VIC_ID_W = 5;
  localparam int unsigned VIC_PRIO_W = 3;
  localparam int unsigned VIC_TYPE_W = 2;
  localparam int unsigned VIC_STACK_DEPTH = 8;
  localparam int unsigned VIC_EVT_W = 3;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [31:0] VIC_ADDR_SMR_BASE = 32'hfffff000;
  localparam logic [31:0] VIC_ADDR_SVR_BASE = 32'hfffff080;
  localparam logic [31:0] VIC_ADDR_IVR = 32'hfffff100;
  localparam logic [31:0] VIC_ADDR_FVR = 32'hfffff104;
  localparam logic [31:0] VIC_ADDR_ISR = 32'hfffff108;
  localparam logic [31:0] VIC_ADDR_IPR = 32'hfffff10c;
  localparam logic [31:0] VIC_ADDR_IMR = 32'hfffff110;
  localparam logic [31:0] VIC_ADDR_CISR = 32'hfffff114;
  localparam logic [31:0] VIC_ADDR_IECR = 32'hfffff120;
  localparam logic [31:0] VIC_ADDR_IDCR = 32'hfffff124;
  localparam logic [31:0] VIC_ADDR_ICCR = 32'hfffff128;
  localparam logic [31:0] VIC_ADDR_ISCR = 32'hfffff12c;
  localparam logic [31:0] VIC_ADDR_EOICR = 32'hfffff130;
  localparam logic [31:0] VIC_ADDR_SPU = 32'hfffff134;
  localparam logic [31:0] VIC_ADDR_EVT_STAT = 32'hfffff138;
  localparam logic [31:0] VIC_ADDR_EVT_CLR = 32'hfffff13c;
  localparam logic [31:0] VIC_ADDR_EVT_EN = 32'hfffff140;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned VIC_ARR_LSB = 7;
  localparam int unsigned VIC_IDX_LSB = 2;
  localparam int unsigned VIC_PRIO_LSB = 0;
  localparam int unsigned VIC_TYPE_LSB = 5;
  localparam int unsigned VIC_CISR_NORMAL_REQUEST_N_BIT = 1;
  localparam int unsigned VIC_CISR_FAST_REQUEST_N_BIT = 0;
  localparam int unsigned VIC_EVT_IVR_SPUR = 0;
  localparam int unsigned VIC_EVT_FVR_SPUR = 1;
  localparam int unsigned VIC_EVT_EOI_EMPTY = 2;
  localparam logic [31:0] VIC_RST_WORD = 32'h00000000;
  localparam logic [31:0] VIC_EXT_SRC_DEFAULT = 32'h30000001;

  typedef enum logic [1:0] {
    VIC_TYPE_LOW_LEVEL,
    VIC_TYPE_NEG_EDGE,
    VIC_TYPE_HIGH_LEVEL,
    VIC_TYPE_POS_EDGE
  } vic_srctype_t;

endpackage

// >>> vic_prio_stack.sv
// Stack of nested service levels and source numbers
module vic_prio_stack
  import vic_pkg::*;
#(
  parameter int unsigned DEPTH = VIC_STACK_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_ni,
  vic_stk_if.stk stk
);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [VIC_PRIO_W-1:0] lvl_mem [DEPTH];
  logic [VIC_ID_W-1:0] id_mem [DEPTH];
  logic [CW-1:0] cnt_r;
  logic [AW-1:0] top_idx;
  logic [AW-1:0] wr_idx;
  logic can_push;

  assign top_idx = AW'(cnt_r - CW'(1));
  assign wr_idx = AW'(cnt_r);
  assign can_push = cnt_r < CW'(DEPTH);
  assign stk.empty = cnt_r == '0;
  assign stk.top_lvl = stk.empty ? '0 : lvl_mem[top_idx];
  assign stk.top_id = stk.empty ? '0 : id_mem[top_idx];

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      cnt_r <= '0;
    end else if (stk.push && can_push) begin
      cnt_r <= cnt_r + CW'(1);
    end else if (stk.pop && !stk.empty) begin
      cnt_r <= cnt_r - CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (stk.push && can_push) begin
      lvl_mem[wr_idx] <= stk.push_lvl;
      id_mem[wr_idx] <= stk.push_id;
    end
  end
endmodule

// >>> vic_src_cond.sv
// Per-source input synchroniser, trigger detection and pending flag
module vic_src_cond
  import vic_pkg::*;
#(
  parameter bit EXTERNAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic src_i,
  input wire logic [VIC_TYPE_W-1:0] type_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic pend_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic flag_r;
  logic flag_nxt;
  logic is_edge;
  logic low_sense;
  logic edge_hit;
  logic level_on;

  // Internal sources ignore the upper type bit
  assign is_edge = type_i[0];
  assign low_sense = EXTERNAL && !type_i[1];
  assign edge_hit = low_sense ? (prev_r & ~sync_r) : (sync_r & ~prev_r);
  assign level_on = low_sense ? ~sync_r : sync_r;
  // Set wins over clear
  assign flag_nxt = is_edge & ((edge_hit | set_i) | (flag_r & ~clr_i));
  assign pend_o = is_edge ? flag_r : level_on;

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      meta_r <= src_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
      flag_r <= flag_nxt;
    end
  end
endmodule

// >>> vic_src_model.sv
// Model of the peripheral and external interrupt source lines
module vic_src_model
  import vic_pkg::*;
(
  input wire logic clk_i,
  input wire logic [VIC_NSRC-1:0] lvl_i,
  output logic [VIC_NSRC-1:0] src_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines move only after a clock edge, like a peripheral flop
  always @(posedge clk_i) src_o <= lvl_i;
endmodule

// >>> vic_stk_if.sv
// Interface between the arbiter and the priority stack
interface vic_stk_if;
  import vic_pkg::*;
  logic push;
  logic pop;
  logic [VIC_PRIO_W-1:0] push_lvl;
  logic [VIC_ID_W-1:0] push_id;
  logic [VIC_PRIO_W-1:0] top_lvl;
  logic [VIC_ID_W-1:0] top_id;
  logic empty;

  modport ctrl (output push, output pop, output push_lvl, output push_id,
                input top_lvl, input top_id, input empty);
  modport stk (input push, input pop, input push_lvl, input push_id,
               output top_lvl, output top_id, output empty);
endinterface

// >>> vic_top.sv
// Vectored priority interrupt controller with register port
// Operation
// - Each source has a mode register; priority bits 2..0, 0 lowest, 7 highest.
// - Source 0 priority is not used when arbitrating normal interrupts.
// - External type: 00 low level, 01 falling edge, 10 high level, 11 rising edge.
// - Internal type: 00 and 10 high level, 01 and 11 rising edge.
// - Internal sources read the upper type bit as zero.
// - Each source has a read/write 32-bit handler address register.
// - Normal vector read returns the handler address of the current interrupt.
// - Normal vector reads the spurious vector when no interrupt is current.
// - Fast vector read returns the handler address of source 0.
// - Enable, disable, clear, set and end-of-service registers are write-only commands.
// - Mode, vector, status, mask, core line and spurious registers reset to zero.
// - Current source register bits 4..0 give the serviced source number.
// - Normal vector read makes best source current, pushes level, clears edge, drops request.
// - End-of-service write pops level; request returns if pending source outranks it.
// - Vector read with its request line inactive returns the spurious vector.
//
// The implementer's own choice: strobed register access.
module vic_top
  import vic_pkg::*;
#(
  parameter logic [VIC_NSRC-1:0] EXT_SRC = VIC_EXT_SRC_DEFAULT
) (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic [31:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic [VIC_NSRC-1:0] SRC_I,
  output logic NORMAL_REQUEST_N_O,
  output logic FAST_REQUEST_N_O,
  output logic EVENT_IRQ_O
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ****************************************
  // Registers and state
  // ****************************************
  logic [VIC_PRIO_W-1:0] prio_r [VIC_NSRC];
  logic [VIC_TYPE_W-1:0] type_r [VIC_NSRC];
  logic [31:0] svr_r [VIC_NSRC];
  logic [31:0] spu_r;
  logic [VIC_NSRC-1:0] mask_r;
  logic [VIC_NSRC-1:0] mask_nxt;
  logic [VIC_EVT_W-1:0] evt_r;
  logic [VIC_EVT_W-1:0] evt_nxt;
  logic [VIC_EVT_W-1:0] evt_en_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic fiq_r;
  logic fiq_nxt;
  logic evt_irq_r;
  logic irq_n_r;
  logic fiq_n_r;
  logic irq_live;
  logic [VIC_NSRC-1:0] mask_set;
  logic [VIC_NSRC-1:0] mask_clr;
  logic [VIC_EVT_W-1:0] evt_clr_vec;
  logic [VIC_EVT_W-1:0] evt_en_nxt;

  // ****************************************
  // Address decode
  // ****************************************
  logic [VIC_ID_W-1:0] idx;
  logic hit_smr;
  logic hit_svr;
  logic wr_smr;
  logic wr_svr;
  logic rd_ivr;
  logic rd_fvr;
  logic wr_iecr;
  logic wr_idcr;
  logic wr_iccr;
  logic wr_iscr;
  logic wr_eoicr;
  logic wr_spu;
  logic wr_evt_clr;
  logic wr_evt_en;

  assign idx = ADDR_I[VIC_ARR_LSB-1:VIC_IDX_LSB];
  assign hit_smr = ADDR_I[31:VIC_ARR_LSB] == VIC_ADDR_SMR_BASE[31:VIC_ARR_LSB];
  assign hit_svr = ADDR_I[31:VIC_ARR_LSB] == VIC_ADDR_SVR_BASE[31:VIC_ARR_LSB];
  assign wr_smr = WR_I && hit_smr;
  assign wr_svr = WR_I && hit_svr;
  assign rd_ivr = RD_I && ADDR_I == VIC_ADDR_IVR;
  assign rd_fvr = RD_I && ADDR_I == VIC_ADDR_FVR;
  assign wr_iecr = WR_I && ADDR_I == VIC_ADDR_IECR;
  assign wr_idcr = WR_I && ADDR_I == VIC_ADDR_IDCR;
  assign wr_iccr = WR_I && ADDR_I == VIC_ADDR_ICCR;
  assign wr_iscr = WR_I && ADDR_I == VIC_ADDR_ISCR;
  assign wr_eoicr = WR_I && ADDR_I == VIC_ADDR_EOICR;
  assign wr_spu = WR_I && ADDR_I == VIC_ADDR_SPU;
  assign wr_evt_clr = WR_I && ADDR_I == VIC_ADDR_EVT_CLR;
  assign wr_evt_en = WR_I && ADDR_I == VIC_ADDR_EVT_EN;

  // ****************************************
  // Source conditioning
  // ****************************************
  logic [VIC_NSRC-1:0] pend;
  logic [VIC_NSRC-1:0] active;
  logic [VIC_NSRC-1:0] set_vec;
  logic [VIC_NSRC-1:0] clr_vec;
  logic [VIC_NSRC-1:0] auto_clr;
  logic [VIC_NSRC-1:0] best_onehot;

  assign set_vec = wr_iscr ? WDATA_I : '0;
  assign clr_vec = (wr_iccr ? WDATA_I : '0) | auto_clr;
  assign active = pend & mask_r;

  for (genvar g = 0; g < VIC_NSRC; g++) begin : g_src
    vic_src_cond #(
      .EXTERNAL(EXT_SRC[g])
    ) u_cond (
      .clk_i(CLK_SYS_I),
      .rst_ni(rst_n),
      .src_i(SRC_I[g]),
      .type_i(type_r[g]),
      .set_i(set_vec[g]),
      .clr_i(clr_vec[g]),
      .pend_o(pend[g])
    );
  end

  // ****************************************
  // Arbitration
  // ****************************************
  vic_stk_if stk_if ();
  logic best_ok;
  logic [VIC_ID_W-1:0] best_id;
  logic [VIC_PRIO_W-1:0] best_lvl;
  logic irq_want;
  logic irq_take;
  logic fiq_take;

  // Downward scan with >= lets the lower number win a tie
  always_comb begin
    best_ok = 1'b0;
    best_id = '0;
    best_lvl = '0;
    for (int i = VIC_NSRC - 1; i >= 1; i--) begin
      if (active[i] && (!best_ok || prio_r[i] >= best_lvl)) begin
        best_ok = 1'b1;
        best_id = VIC_ID_W'(i);
        best_lvl = prio_r[i];
      end
    end
  end

  assign irq_want = best_ok && (stk_if.empty || best_lvl > stk_if.top_lvl);
  // A source that left since the request rose is not taken
  assign irq_live = irq_r && irq_want;
  assign irq_take = rd_ivr && irq_live;
  assign fiq_take = rd_fvr && fiq_r;
  assign best_onehot = VIC_NSRC'(1) << best_id;
  // Edge sources are cleared when taken
  assign auto_clr = (irq_take && type_r[best_id][0] ? best_onehot : '0)
                    | {{(VIC_NSRC-1){1'b0}}, fiq_take && type_r[0][0]};

  assign stk_if.push = irq_take;
  assign stk_if.push_lvl = best_lvl;
  assign stk_if.push_id = best_id;
  assign stk_if.pop = wr_eoicr;

  vic_prio_stack #(
    .DEPTH(VIC_STACK_DEPTH)
  ) u_stack (
    .clk_i(CLK_SYS_I),
    .rst_ni(rst_n),
    .stk(stk_if.stk)
  );

  // Normal request drops in the cycle after the taking read; fast only for an edge source 0
  assign irq_nxt = irq_want && !irq_take;
  assign fiq_nxt = active[0] && !(fiq_take && type_r[0][0]);

  // ****************************************
  // Mask and event status
  // ****************************************
  logic [VIC_EVT_W-1:0] evt_set;

  assign mask_set = wr_iecr ? WDATA_I : '0;
  assign mask_clr = wr_idcr ? WDATA_I : '0;
  assign mask_nxt = (mask_r | mask_set) & ~mask_clr;
  assign evt_set = {wr_eoicr && stk_if.empty, rd_fvr && !fiq_r, rd_ivr && !irq_live};
  assign evt_clr_vec = wr_evt_clr ? WDATA_I[VIC_EVT_W-1:0] : '0;
  // Set wins over clear
  assign evt_nxt = evt_set | (evt_r & ~evt_clr_vec);
  assign evt_en_nxt = wr_evt_en ? WDATA_I[VIC_EVT_W-1:0] : evt_en_r;

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] mode_word;
  logic [31:0] ivr_word;
  logic [31:0] fvr_word;
  logic [31:0] cisr_word;

  assign mode_word = {{(32-VIC_TYPE_LSB-VIC_TYPE_W){1'b0}}, type_r[idx],
                      {(VIC_TYPE_LSB-VIC_PRIO_W){1'b0}}, prio_r[idx]};
  // Spurious vector resets to zero, so an idle read gives zero
  assign ivr_word = irq_live ? svr_r[best_id] : spu_r;
  assign fvr_word = fiq_r ? svr_r[0] : spu_r;
  assign cisr_word = (32'(irq_r) << VIC_CISR_NORMAL_REQUEST_N_BIT) | (32'(fiq_r) << VIC_CISR_FAST_REQUEST_N_BIT);

  always_comb begin
    rdata_nxt = VIC_RST_WORD;
    if (RD_I) begin
      if (hit_smr) begin
        rdata_nxt = mode_word;
      end else if (hit_svr) begin
        rdata_nxt = svr_r[idx];
      end else begin
        case (ADDR_I)
          VIC_ADDR_IVR: rdata_nxt = ivr_word;
          VIC_ADDR_FVR: rdata_nxt = fvr_word;
          VIC_ADDR_ISR: rdata_nxt = 32'(stk_if.top_id);
          VIC_ADDR_IPR: rdata_nxt = pend;
          VIC_ADDR_IMR: rdata_nxt = mask_r;
          VIC_ADDR_CISR: rdata_nxt = cisr_word;
          VIC_ADDR_SPU: rdata_nxt = spu_r;
          VIC_ADDR_EVT_STAT: rdata_nxt = 32'(evt_r);
          VIC_ADDR_EVT_EN: rdata_nxt = 32'(evt_en_r);
          default: rdata_nxt = VIC_RST_WORD;
        endcase
      end
    end
  end

  // ****************************************
  // Mode and vector tables
  // ****************************************
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < VIC_NSRC; i++) begin
        prio_r[i] <= '0;
        type_r[i] <= '0;
      end
    end else if (wr_smr) begin
      prio_r[idx] <= WDATA_I[VIC_PRIO_LSB +: VIC_PRIO_W];
      type_r[idx] <= {WDATA_I[VIC_TYPE_LSB+1] & EXT_SRC[idx], WDATA_I[VIC_TYPE_LSB]};
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < VIC_NSRC; i++) begin
        svr_r[i] <= VIC_RST_WORD;
      end
    end else if (wr_svr) begin
      svr_r[idx] <= WDATA_I;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      spu_r <= VIC_RST_WORD;
    end else if (wr_spu) begin
      spu_r <= WDATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= '0;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      evt_r <= '0;
      evt_en_r <= '0;
    end else begin
      evt_r <= evt_nxt;
      evt_en_r <= evt_en_nxt;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= VIC_RST_WORD;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  // Active-low copies kept in flops so the pins need no inverter
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
      irq_n_r <= 1'b1;
    end else begin
      irq_r <= irq_nxt;
      irq_n_r <= ~irq_nxt;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      fiq_r <= 1'b0;
      fiq_n_r <= 1'b1;
    end else begin
      fiq_r <= fiq_nxt;
      fiq_n_r <= ~fiq_nxt;
    end
  end

  // Level output follows the enable as it is written
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      evt_irq_r <= 1'b0;
    end else begin
      evt_irq_r <= |(evt_nxt & evt_en_nxt);
    end
  end

  assign RDATA_O = rdata_r;
  assign NORMAL_REQUEST_N_O = irq_n_r;
  assign FAST_REQUEST_N_O = fiq_n_r;
  assign EVENT_IRQ_O = evt_irq_r;

endmodule
